/* design/operating_mode_select.sv */
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module operating_mode_select #(
	parameter logic [15:0] RAM_BASE = opmode_pkg::RAM_BASE_RESET,
	parameter logic [15:0] RAM_LAST = opmode_pkg::RAM_LAST_RESET,
	parameter logic [15:0] ROM_LAST = opmode_pkg::ROM_LAST_RESET
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        mode_strap_high,
	input  wire logic        mode_strap_low,
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [7:0]  reg_rdata,
	input  wire logic [15:0] cpu_addr,
	input  wire logic        cpu_req,
	output var  logic        sel_rom_q,
	output var  logic        sel_ram_q,
	output var  logic        sel_ext_q,
	output var  logic        ext_bus_en_q,
	output var  logic        ports_gpio_q,
	output var  logic        mode_valid_q,
	output var  logic [1:0]  mode_num_q,
	output var  logic        standby_sel_q,
	output var  logic [2:0]  settle_sel_q,
	output var  logic        nmi_rise_q
);
	// ==========================================
	// strap synchronisation
	logic [1:0] strap_sync;
	pin_sync #(.WIDTH(2)) u_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.async_in ({mode_strap_high, mode_strap_low}),
		.sync_out (strap_sync)
	);

	// ==========================================
	// mode capture after reset release
	logic [1:0]           cap_cnt_q;
	logic                 captured_q;
	opmode_pkg::op_mode_t mode_q;
	opmode_pkg::op_mode_t mode_d;
	wire                  cap_now = !captured_q && (cap_cnt_q == 2'h2);

	// decode of straps into a mode
	always_comb begin
		unique case (strap_sync)
			2'h1:    mode_d = opmode_pkg::MODE_EXP_NR;
			2'h2:    mode_d = opmode_pkg::MODE_EXP_R;
			2'h3:    mode_d = opmode_pkg::MODE_SINGLE;
			default: mode_d = opmode_pkg::MODE_NONE;
		endcase
	end

	// wait for the synchroniser to fill, then freeze
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cap_cnt_q  <= 2'h0;
			captured_q <= 1'b0;
			mode_q     <= opmode_pkg::MODE_NONE;
		end else begin
			if (!captured_q && cap_cnt_q != 2'h2)
				cap_cnt_q <= cap_cnt_q + 2'h1;
			if (cap_now) begin
				captured_q <= 1'b1;
				mode_q     <= mode_d;
			end
		end
	end

	// ==========================================
	// register decode
	wire hit_sc = (reg_addr == opmode_pkg::SYSTEM_CONTROL_ADDR);
	wire hit_mi = (reg_addr == opmode_pkg::MODE_INDICATOR_ADDR);
	wire wr_sc  = reg_wr && hit_sc;
	wire rd_mi  = reg_rd && hit_mi;

	logic [7:0] sc_q;
	logic [1:0] mi_latch_q;
	wire  [7:0] sc_d = (reg_wdata & opmode_pkg::SC_WRITE_MASK) | opmode_pkg::SC_FIXED_ONES;
	logic [7:0] sc_d_past;

	// system control storage; reset sets RAM enable, writes can set or clear it
	always_ff @(posedge clk) begin
		if (!rst_b)
			sc_q <= opmode_pkg::SC_RESET_VALUE;
		else if (wr_sc)
			sc_q <= sc_d;
	end

	// mode indicator bits follow pins at each read, writes have no path
	always_ff @(posedge clk) begin
		if (!rst_b)
			mi_latch_q <= 2'h0;
		else if (cap_now)
			mi_latch_q <= strap_sync;
		else if (rd_mi)
			mi_latch_q <= strap_sync;
	end

	// read data one cycle after the strobe
	wire [7:0] mi_view = opmode_pkg::MI_FIXED_BITS | {6'h00, strap_sync};
	wire [7:0] rd_mux  = hit_sc ? sc_q : (hit_mi ? mi_view : 8'h00);
	always_ff @(posedge clk) begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 8'h00;
	end

	// ==========================================
	// address routing
	wire ram_en  = sc_q[opmode_pkg::SC_RAM_ENABLE_BIT];
	wire in_ram  = (cpu_addr >= RAM_BASE) && (cpu_addr <= RAM_LAST);
	wire in_rom  = (cpu_addr <= ROM_LAST);
	wire in_regs = (cpu_addr > RAM_LAST);
	wire is_exp  = (mode_q == opmode_pkg::MODE_EXP_NR) || (mode_q == opmode_pkg::MODE_EXP_R);
	wire rom_on  = (mode_q == opmode_pkg::MODE_EXP_R) || (mode_q == opmode_pkg::MODE_SINGLE);
	wire go_ram  = in_ram && ram_en;
	wire go_rom  = in_rom && rom_on && !go_ram;
	wire go_ext  = is_exp && !go_ram && !go_rom && !in_regs;

	// registered select outputs
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sel_rom_q <= 1'b0;
			sel_ram_q <= 1'b0;
			sel_ext_q <= 1'b0;
		end else begin
			sel_rom_q <= cpu_req && go_rom;
			sel_ram_q <= cpu_req && go_ram;
			sel_ext_q <= cpu_req && go_ext;
		end
	end

	// mode and control status outputs
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ext_bus_en_q  <= 1'b0;
			ports_gpio_q  <= 1'b0;
			mode_valid_q  <= 1'b0;
			mode_num_q    <= 2'h0;
			standby_sel_q <= 1'b0;
			settle_sel_q  <= 3'h0;
			nmi_rise_q    <= 1'b0;
		end else begin
			ext_bus_en_q  <= is_exp;
			ports_gpio_q  <= (mode_q == opmode_pkg::MODE_SINGLE);
			mode_valid_q  <= captured_q && (mode_q != opmode_pkg::MODE_NONE);
			mode_num_q    <= is_exp ? (rom_on ? 2'h2 : 2'h1) : (rom_on ? 2'h3 : 2'h0);
			standby_sel_q <= sc_q[opmode_pkg::SC_STANDBY_BIT];
			settle_sel_q  <= sc_q[opmode_pkg::SC_SETTLE_LSB +: 3];
			nmi_rise_q    <= sc_q[opmode_pkg::SC_NMI_EDGE_BIT];
		end
	end

	// ==========================================
	// checks
	mode_frozen_a: assert property (@(posedge clk) disable iff (!rst_b)
		captured_q |=> $stable(mode_q))
		else $error("mode changed after capture");

	mode_one_a: assert property (@(posedge clk) disable iff (!rst_b)
		cap_now && strap_sync == 2'h1 |=> mode_q == opmode_pkg::MODE_EXP_NR)
		else $error("mode 1 not taken");

	mode_two_a: assert property (@(posedge clk) disable iff (!rst_b)
		cap_now && strap_sync == 2'h2 |=> mode_q == opmode_pkg::MODE_EXP_R)
		else $error("mode 2 not taken");

	mode_three_a: assert property (@(posedge clk) disable iff (!rst_b)
		cap_now && strap_sync == 2'h3 |=> ##1 ports_gpio_q && !ext_bus_en_q)
		else $error("mode 3 outputs wrong");

	capture_time_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(rst_b) |-> ##[1:3] captured_q)
		else $error("mode not captured in time");

	ram_off_a: assert property (@(posedge clk) disable iff (!rst_b)
		cpu_req && in_ram && !ram_en && is_exp |=> sel_ext_q && !sel_ram_q)
		else $error("ram range not routed off chip");

	single_no_ext_a: assert property (@(posedge clk) disable iff (!rst_b)
		mode_q == opmode_pkg::MODE_SINGLE |=> !sel_ext_q)
		else $error("external access in single chip mode");

	sc_readback_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_sc ##1 (reg_rd && hit_sc) |=> reg_rdata == sc_d_past)
		else $error("system control readback wrong");

	mi_read_a: assert property (@(posedge clk) disable iff (!rst_b)
		rd_mi |=> reg_rdata == (opmode_pkg::MI_FIXED_BITS | {6'h00, $past(strap_sync)}))
		else $error("mode indicator read wrong");

	mi_latch_a: assert property (@(posedge clk) disable iff (!rst_b)
		rd_mi |=> mi_latch_q == $past(strap_sync))
		else $error("mode bits not latched on read");

	ram_reset_a: assert property (@(posedge clk)
		!rst_b |=> sc_q[opmode_pkg::SC_RAM_ENABLE_BIT])
		else $error("ram enable not set by reset");

	mi_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && hit_mi && !rd_mi && !cap_now |=> $stable(mi_latch_q) && $stable(sc_q))
		else $error("mode indicator write took effect");

	// helper for readback check: value of the last system control write
	always_ff @(posedge clk) begin
		if (!rst_b)
			sc_d_past <= 8'h00;
		else if (wr_sc)
			sc_d_past <= sc_d;
	end
endmodule : operating_mode_select
`default_nettype wire

/* design/opmode_pkg.sv */
package opmode_pkg;
	// register offsets
	localparam logic [15:0] SYSTEM_CONTROL_ADDR = 16'hFFC4;
	localparam logic [15:0] MODE_INDICATOR_ADDR = 16'hFFC5;
	// system control layout and reset value
	localparam int          SC_STANDBY_BIT      = 7;
	localparam int          SC_SETTLE_LSB       = 4;
	localparam int          SC_NMI_EDGE_BIT     = 2;
	localparam int          SC_RAM_ENABLE_BIT   = 0;
	localparam logic [7:0]  SC_RESET_VALUE      = 8'h0B;
	localparam logic [7:0]  SC_FIXED_ONES       = 8'h0A;
	localparam logic [7:0]  SC_WRITE_MASK       = 8'hF5;
	// mode indicator fixed bits
	localparam logic [7:0]  MI_FIXED_BITS       = 8'hE4;
	// on-chip RAM window and ROM end, chosen defaults
	localparam logic [15:0] RAM_BASE_RESET      = 16'hFB80;
	localparam logic [15:0] RAM_LAST_RESET      = 16'hFF7F;
	localparam logic [15:0] ROM_LAST_RESET      = 16'h7FFF;
	// mode codes
	typedef enum logic [3:0] {
		MODE_NONE   = 4'h1,
		MODE_EXP_NR = 4'h2,
		MODE_EXP_R  = 4'h4,
		MODE_SINGLE = 4'h8
	} op_mode_t;
endpackage : opmode_pkg

/* design/strap_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a bundle of pins
module pin_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : pin_sync
`default_nettype wire

/* verification/operating_mode_select_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module operating_mode_select_tb;
	logic        clk, rst_b, reg_wr, reg_rd, cpu_req, sh, sl;
	logic [15:0] reg_addr, cpu_addr, a;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [1:0]  mode_sel, mode_num_q;
	logic [2:0]  settle_sel_q;
	logic        sel_rom_q, sel_ram_q, sel_ext_q, ext_bus_en_q, ports_gpio_q;
	logic        mode_valid_q, standby_sel_q, nmi_rise_q;
	int          n_fail, compares, m;
	// ==========================================
	// design and board
	strap_board board (.mode_sel(mode_sel), .mode_strap_high(sh), .mode_strap_low(sl));
	operating_mode_select dut (.clk(clk), .rst_b(rst_b), .mode_strap_high(sh),
		.mode_strap_low(sl), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr), .cpu_req(cpu_req),
		.sel_rom_q(sel_rom_q), .sel_ram_q(sel_ram_q), .sel_ext_q(sel_ext_q),
		.ext_bus_en_q(ext_bus_en_q), .ports_gpio_q(ports_gpio_q),
		.mode_valid_q(mode_valid_q), .mode_num_q(mode_num_q),
		.standby_sel_q(standby_sel_q), .settle_sel_q(settle_sel_q),
		.nmi_rise_q(nmi_rise_q));
	// ==========================================
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		complete_run();
	end
	// ==========================================
	// helpers
	task automatic complete_run();
		if (n_fail == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [15:0] ad, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] ad, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", e, reg_rdata);
	endtask : rd
	// expected route as {rom, ram, ext}
	function automatic logic [7:0] route(input int md, input logic r, input logic [15:0] ad);
		if (ad >= 16'hFF80) return 8'h00;
		if (ad >= opmode_pkg::RAM_BASE_RESET && ad <= opmode_pkg::RAM_LAST_RESET && r)
			return 8'h02;
		if (ad <= opmode_pkg::ROM_LAST_RESET && md != 1) return 8'h04;
		return (md == 3) ? 8'h00 : 8'h01;
	endfunction : route
	task automatic req(input logic [15:0] ad, input logic r);
		@(posedge clk);
		cpu_addr <= ad;
		cpu_req <= 1'b1;
		@(posedge clk);
		cpu_req <= 1'b0;
		#1 chk("route", route(m, r, ad), {5'h00, sel_rom_q, sel_ram_q, sel_ext_q});
	endtask : req
	// ==========================================
	// main sequence: modes 1 to 3, each from reset
	initial begin
		{rst_b, reg_wr, reg_rd, cpu_req, reg_wdata} = '0;
		{reg_addr, cpu_addr} = '0;
		mode_sel = 2'h1;
		n_fail = 0;
		compares = 0;
		void'($urandom(32'hBCCC));
		for (m = 1; m <= 3; m++) begin
			mode_sel <= m[1:0];
			rst_b <= 1'b0;
			repeat (16) @(posedge clk);
			rst_b <= 1'b1;
			repeat (8) @(posedge clk);
			#1 chk("mode", m[7:0], {6'h00, mode_num_q});
			chk("ext_bus", {7'h00, m != 3}, {7'h00, ext_bus_en_q});
			chk("gpio", {7'h00, m == 3}, {7'h00, ports_gpio_q});
			chk("valid", 8'h01, {7'h00, mode_valid_q});
			rd(opmode_pkg::SYSTEM_CONTROL_ADDR, 8'h0B);
			wr(opmode_pkg::MODE_INDICATOR_ADDR, 8'h00);
			rd(opmode_pkg::MODE_INDICATOR_ADDR, 8'hE4 | m[7:0]);
			mode_sel <= (m == 3) ? 2'h1 : m[1:0] + 2'h1;
			repeat (4) @(posedge clk);
			rd(opmode_pkg::MODE_INDICATOR_ADDR, 8'hE4 | {6'h00, sh, sl});
			chk("frozen", m[7:0], {6'h00, mode_num_q});
			req(16'hFF7F, 1'b1);
			req(16'hFF80, 1'b1);
			repeat (20) begin
				a = 16'($urandom);
				if (m == 3) a = a[0] ? {1'b0, a[14:0]} : 16'hFB80 + {9'h000, a[6:0]};
				req(a, 1'b1);
			end
			wr(opmode_pkg::SYSTEM_CONTROL_ADDR, 8'hFF);
			rd(opmode_pkg::SYSTEM_CONTROL_ADDR, 8'hFF);
			#1 chk("standby", 8'h01, {7'h00, standby_sel_q});
			chk("nmi_edge", 8'h01, {7'h00, nmi_rise_q});
			wr(opmode_pkg::SYSTEM_CONTROL_ADDR, 8'h70);
			rd(opmode_pkg::SYSTEM_CONTROL_ADDR, 8'h7A);
			#1 chk("settle", 8'h07, {5'h00, settle_sel_q});
			if (m != 3) req(16'hFB80, 1'b0);
		end
		complete_run();
	end
endmodule : operating_mode_select_tb
`default_nettype wire

/* verification/strap_board.sv */
`timescale 1ns/1ps
`default_nettype none
// board strap pins for the wanted mode
module strap_board (
	input  wire logic [1:0] mode_sel,
	output var  logic       mode_strap_high,
	output var  logic       mode_strap_low
);
	// a request for mode 0 falls back to mode 1, the only safe strap
	always_comb begin
		mode_strap_high = mode_sel[1];
		mode_strap_low  = mode_sel[0] | ~mode_sel[1];
	end
endmodule : strap_board
`default_nettype wire
